// ### common/mcu_pkg.sv
// Functional notes
// - After reset the boot ROM answers from address zero and no RAM bank is decoded.
// - The first access to the normal ROM region leaves remap mode and RAM decodes again.
// - With a ROM module in its socket, the soldered ROM is never selected.
// - Every ROM and RAM access, single or four-beat burst, gets control, timing and acks.
// - The ROM region is one 1 MB window, 32 bits wide, built from two 16-bit devices.
// - Bank one is a fixed 4 MB; bank two is absent, 4 MB or 16 MB.
// - DRAM is run in fast page mode: one row opening serves all beats of a burst.
// - Each RAM bank has a writable start-address register that sets its window.
// - The controller runs synchronously on the single system bus clock.
package mcu_pkg;

  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic        burst;
  } mem_req_type;

  typedef enum logic [3:0] {
    S_IDLE, S_DECODE, S_ROM, S_RAS, S_CAS, S_CAS_PRE, S_PRECHARGE, S_REF_CAS, S_REF_RAS
  } mcu_state_type;

  // Address map in 1 MB units
  localparam logic [11:0] ROM_BASE_MB    = 12'h400;
  localparam logic [11:0] LOW_MB         = 12'h000;
  localparam logic [11:0] BANK1_SIZE_MB  = 12'h004;
  localparam logic [11:0] BANK2_SMALL_MB = 12'h004;
  localparam logic [11:0] BANK2_LARGE_MB = 12'h010;
  localparam logic [11:0] NO_BANK_MB     = 12'h000;
  localparam logic [11:0] BANK1_BASE_RST = 12'h000;
  localparam logic [11:0] BANK2_BASE_RST = 12'h004;

  localparam int          NUM_BANKS   = 2;
  localparam int          NUM_STRAPS  = 3;
  localparam int          ROW_MSB     = 23;
  localparam int          ROW_LSB     = 13;
  localparam int          COL_MSB     = 12;
  localparam int          COL_LSB     = 2;
  localparam int          DRAM_ADDR_W = 11;
  localparam logic [1:0]  LAST_BEAT   = 2'h3;

  // Timing
  localparam int CLOCK_NS       = 10;
  localparam int ROM_ACCESS_NS  = 150;
  localparam int DRAM_ACCESS_NS = 80;
  localparam int RAS_CAS_NS     = 20;
  localparam int CAS_PRE_NS     = 10;
  localparam int PRECHARGE_NS   = 60;
  localparam int REF_SETUP_NS   = 10;
  localparam int REF_RAS_NS     = 80;
  localparam int REFRESH_NS     = 15600;

  localparam int ROM_CYC       = (ROM_ACCESS_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int CAS_CYC       = (DRAM_ACCESS_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int RAS_CAS_CYC   = (RAS_CAS_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int CAS_PRE_CYC   = (CAS_PRE_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int PRECHARGE_CYC = (PRECHARGE_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int REF_SETUP_CYC = (REF_SETUP_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int REF_RAS_CYC   = (REF_RAS_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int REFRESH_CYC   = REFRESH_NS / CLOCK_NS;

endpackage

// ### core/bank_window.sv
`timescale 1ns/100ps
module bank_window
  import mcu_pkg::*;
(
  input  wire logic [31:0] addr_i,
  input  wire logic [11:0] base_mb_i,
  input  wire logic [11:0] size_mb_i,
  output logic             hit_o,
  output logic [23:0]      offset_o
);

  logic [11:0] diff;

  // Difference form avoids wrap when base plus size passes the top of the map
  always_comb begin
    diff     = addr_i[31:20] - base_mb_i;
    hit_o    = (size_mb_i != NO_BANK_MB) && (addr_i[31:20] >= base_mb_i) && (diff < size_mb_i);
    offset_o = {diff[3:0], addr_i[19:0]};
  end

endmodule

// ### core/memory_control_unit.sv
`timescale 1ns/100ps
module memory_control_unit
  import mcu_pkg::*;
(
  input  wire logic                   clock_i,
  input  wire logic                   reset_n_i,
  input  wire logic                   start_i,
  input  wire mem_req_type            req_i,
  input  wire logic                   base_wr_i,
  input  wire logic                   base_sel_i,
  input  wire logic [11:0]            base_data_i,
  input  wire logic                   rom_module_present_i,
  input  wire logic                   bank2_populated_i,
  input  wire logic                   bank2_large_i,
  output logic                        ack_o,
  output logic                        error_o,
  output logic                        remap_o,
  output logic                        rom_board_ce_n_o,
  output logic                        rom_module_ce_n_o,
  output logic                        rom_oe_n_o,
  output logic [1:0]                  rom_word_o,
  output logic [NUM_BANKS-1:0]        ras_n_o,
  output logic                        cas_n_o,
  output logic                        we_n_o,
  output logic [DRAM_ADDR_W-1:0]      dram_addr_o
);

  localparam int ROM_ACK_DELAY = ROM_CYC - 1;

  mcu_state_type        state;
  mem_req_type          cur;
  logic                 req_pend;
  logic                 ref_pend;
  logic [11:0]          ref_cnt;
  logic [7:0]           cnt;
  logic [1:0]           beat;
  logic                 bank;
  logic                 remap;
  logic [NUM_STRAPS-1:0] strap_meta;
  logic [NUM_STRAPS-1:0] strap_sync;
  logic [11:0]          base_mb [NUM_BANKS];
  logic [11:0]          size_mb [NUM_BANKS];
  logic [NUM_BANKS-1:0] hit;
  logic [23:0]          offset [NUM_BANKS];
  logic                 rom_normal;
  logic                 low_region;
  logic                 module_in;
  logic                 row_open;
  logic [DRAM_ADDR_W-1:0] col;

  ////////////////////////////////////////////////////////////////////////////
  // Strap pins from outside pass two flops before use
  generate
    for (genvar s = 0; s < NUM_STRAPS; s++) begin : g_sync
      always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
          strap_meta[s] <= 1'b0;
          strap_sync[s] <= 1'b0;
        end else begin
          strap_meta[s] <= (s == 0) ? rom_module_present_i :
                           (s == 1) ? bank2_populated_i : bank2_large_i;
          strap_sync[s] <= strap_meta[s];
        end
      end
    end
  endgenerate

  assign module_in = strap_sync[0];

  ////////////////////////////////////////////////////////////////////////////
  // Bank start registers and window decode
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      base_mb[0] <= BANK1_BASE_RST;
      base_mb[1] <= BANK2_BASE_RST;
    end else if (base_wr_i) begin
      base_mb[base_sel_i] <= base_data_i;
    end
  end

  always_comb begin
    size_mb[0] = BANK1_SIZE_MB;
    size_mb[1] = !strap_sync[1] ? NO_BANK_MB :
                 strap_sync[2] ? BANK2_LARGE_MB : BANK2_SMALL_MB;
  end

  generate
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
      bank_window u_window (
        .addr_i    (cur.addr),
        .base_mb_i (base_mb[b]),
        .size_mb_i (size_mb[b]),
        .hit_o     (hit[b]),
        .offset_o  (offset[b])
      );
    end
  endgenerate

  // The ROM window is a single 1 MB slot, so one megabyte compare decodes it
  assign rom_normal = (cur.addr[31:20] == ROM_BASE_MB);
  assign low_region = (cur.addr[31:20] == LOW_MB);

  ////////////////////////////////////////////////////////////////////////////
  // Request capture; the set wins over the clear so a start is never lost
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      cur      <= '0;
      req_pend <= 1'b0;
    end else if (start_i) begin
      cur      <= req_i;
      req_pend <= 1'b1;
    end else if (state == S_IDLE) begin
      req_pend <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Refresh timer, all on the one bus clock
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      ref_cnt  <= '0;
      ref_pend <= 1'b0;
    end else begin
      if (ref_cnt == 12'(REFRESH_CYC - 1)) begin
        ref_cnt  <= '0;
        ref_pend <= 1'b1;
      end else begin
        ref_cnt <= ref_cnt + 12'h001;
        if (state == S_IDLE && !req_pend && ref_pend)
          ref_pend <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Remap mode: ROM at zero after reset until the normal ROM space is touched
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      remap <= 1'b1;
    end else if (state == S_DECODE && rom_normal) begin
      remap <= 1'b0;
    end
  end

  assign remap_o = remap;

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      state   <= S_IDLE;
      cnt     <= '0;
      beat    <= '0;
      bank    <= 1'b0;
      ack_o   <= 1'b0;
      error_o <= 1'b0;
    end else begin
      ack_o   <= 1'b0;
      error_o <= 1'b0;
      case (state)
        S_IDLE: begin
          if (req_pend) begin
            state <= S_DECODE;
          end else if (ref_pend) begin
            state <= S_REF_CAS;
            cnt   <= 8'(REF_SETUP_CYC - 1);
          end
        end
        S_DECODE: begin
          beat <= '0;
          if (rom_normal || (remap && low_region && !cur.write)) begin
            state <= S_ROM;
            cnt   <= 8'(ROM_CYC - 1);
          end else if (remap && low_region) begin
            ack_o <= 1'b1;
            state <= S_IDLE;
          end else if (!remap && hit != '0) begin
            bank  <= !hit[0];
            state <= S_RAS;
            cnt   <= 8'(RAS_CAS_CYC - 1);
          end else begin
            error_o <= 1'b1;
            state   <= S_IDLE;
          end
        end
        S_ROM: begin
          if (cnt != '0) begin
            cnt <= cnt - 8'h01;
          end else begin
            ack_o <= 1'b1;
            if (cur.burst && beat != LAST_BEAT) begin
              beat <= beat + 2'h1;
              cnt  <= 8'(ROM_CYC - 1);
            end else begin
              state <= S_IDLE;
            end
          end
        end
        S_RAS: begin
          if (cnt != '0) begin
            cnt <= cnt - 8'h01;
          end else begin
            state <= S_CAS;
            cnt   <= 8'(CAS_CYC - 1);
          end
        end
        S_CAS: begin
          if (cnt != '0) begin
            cnt <= cnt - 8'h01;
          end else begin
            ack_o <= 1'b1;
            state <= S_CAS_PRE;
            cnt   <= 8'(CAS_PRE_CYC - 1);
          end
        end
        S_CAS_PRE: begin
          if (cnt != '0) begin
            cnt <= cnt - 8'h01;
          end else if (cur.burst && beat != LAST_BEAT) begin
            beat  <= beat + 2'h1;
            state <= S_CAS;
            cnt   <= 8'(CAS_CYC - 1);
          end else begin
            state <= S_PRECHARGE;
            cnt   <= 8'(PRECHARGE_CYC - 1);
          end
        end
        S_PRECHARGE: begin
          if (cnt != '0)
            cnt <= cnt - 8'h01;
          else
            state <= S_IDLE;
        end
        S_REF_CAS: begin
          if (cnt != '0) begin
            cnt <= cnt - 8'h01;
          end else begin
            state <= S_REF_RAS;
            cnt   <= 8'(REF_RAS_CYC - 1);
          end
        end
        S_REF_RAS: begin
          if (cnt != '0) begin
            cnt <= cnt - 8'h01;
          end else begin
            state <= S_PRECHARGE;
            cnt   <= 8'(PRECHARGE_CYC - 1);
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ROM pins
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      rom_board_ce_n_o  <= 1'b1;
      rom_module_ce_n_o <= 1'b1;
      rom_oe_n_o        <= 1'b1;
      rom_word_o        <= '0;
    end else begin
      rom_board_ce_n_o  <= !(state == S_ROM && !module_in);
      rom_module_ce_n_o <= !(state == S_ROM && module_in);
      rom_oe_n_o        <= !(state == S_ROM && !cur.write);
      rom_word_o        <= cur.addr[3:2] + beat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // DRAM pins; the column moves out one cycle before CAS falls
  assign row_open = (state == S_RAS || state == S_CAS || state == S_CAS_PRE);
  // Between page beats the next column goes out in the gap, a cycle ahead of CAS falling
  assign col      = {offset[bank][COL_MSB:COL_LSB+2],
                     offset[bank][COL_LSB+1:COL_LSB] + beat + 2'(state == S_CAS_PRE)};

  generate
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_ras
      always_ff @(posedge clock_i) begin
        if (!reset_n_i)
          ras_n_o[b] <= 1'b1;
        else
          ras_n_o[b] <= !((row_open && bank == b) || state == S_REF_RAS);
      end
    end
  endgenerate

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      cas_n_o     <= 1'b1;
      we_n_o      <= 1'b1;
      dram_addr_o <= '0;
    end else begin
      cas_n_o     <= !(state == S_CAS || state == S_REF_CAS || state == S_REF_RAS);
      we_n_o      <= !(row_open && cur.write);
      dram_addr_o <= (state == S_RAS && cnt != '0) ? offset[bank][ROW_MSB:ROW_LSB] : col;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  logic [2:0] acks_seen;
  always_ff @(posedge clock_i) begin
    if (!reset_n_i || state == S_DECODE)
      acks_seen <= '0;
    else if (ack_o)
      acks_seen <= acks_seen + 3'h1;
  end

  reset_remap_a: assert property ($rose(reset_n_i) |=> remap)
    else $error("remap mode not active after reset");
  // Refresh still strobes every RAS in remap; that is not a decode
  remap_ram_a: assert property (remap |-> &ras_n_o ||
                                state inside {S_REF_RAS, S_PRECHARGE})
    else $error("RAM bank selected in remap mode");
  remap_exit_a: assert property (state == S_DECODE && rom_normal |=> !remap ##1 state == S_ROM)
    else $error("normal ROM access did not leave remap");
  module_select_a: assert property (!rom_board_ce_n_o
                                    |-> !$past(module_in) && rom_module_ce_n_o)
    else $error("board ROM selected with module present");
  burst_beats_a: assert property (state == S_PRECHARGE && $past(state) == S_CAS_PRE
                                  |-> acks_seen == (cur.burst ? 3'h4 : 3'h1))
    else $error("wrong number of DRAM beats");
  rom_wait_a: assert property ($fell(rom_oe_n_o) |-> ##ROM_ACK_DELAY ack_o)
    else $error("ROM ack not at access time");
  page_mode_a: assert property ($rose(cas_n_o) && state == S_CAS |-> !ras_n_o[bank])
    else $error("row closed between page beats");
  bank_window_a: assert property (state == S_RAS |-> hit[bank])
    else $error("DRAM access outside bank window");
  low_write_a: assert property (state == S_DECODE && remap && low_region && cur.write
                                |=> ack_o && rom_oe_n_o ##1 rom_oe_n_o)
    else $error("low write in remap drove ROM");

  rom_burst_c: cover property (state == S_ROM && cur.burst && beat == LAST_BEAT);
  dram_burst_c: cover property (state == S_CAS_PRE && cur.burst && beat == LAST_BEAT);
  remap_exit_c: cover property ($fell(remap));
  refresh_c: cover property (state == S_REF_RAS);

endmodule

// ### verification/host_master_model.sv
`timescale 1ns/100ps
module host_master_model
  import mcu_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  input  wire logic        go_i,
  input  wire mem_req_type next_req_i,
  input  wire logic        ack_i,
  input  wire logic        error_i,
  output logic             start_o,
  output mem_req_type      req_o,
  output logic             done_o
);
  logic [2:0] left;

  // The request port has no snoop control, so the no-snoop code needs no pin here
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      start_o <= 1'b0;
      left    <= 3'h0;
      req_o   <= '0;
    end else if (go_i && left == 3'h0) begin
      start_o <= 1'b1;
      left    <= next_req_i.burst ? 3'h4 : 3'h1;
      req_o   <= next_req_i;
    end else begin
      start_o <= 1'b0;
      if (error_i || (ack_i && left == 3'h1)) begin
        left <= 3'h0;
      end else if (ack_i) begin
        left <= left - 3'h1;
      end
      // Released lines change every cycle, so a stale address cannot pass for a held one
      if (left == 3'h0) begin
        req_o <= ~req_o;
      end
    end
  end

  assign done_o = (left == 3'h0) && !start_o;
endmodule

// ### verification/system_memory_control_unit_tb_top.sv
`timescale 1ns/100ps
module system_memory_control_unit_tb_top;
  import mcu_pkg::*;
  localparam logic [2:0] K_ROM = 3'h0, K_B1 = 3'h1, K_B2 = 3'h2, K_ERR = 3'h3, K_DROP = 3'h4;
  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic        burst;
    logic [2:0]  kind;
  } row_type;

  logic                   clock_i, reset_n_i, go, start, done, ack, error, remap;
  logic                   base_wr, base_sel, mod_in, b2_pop, b2_large;
  logic [11:0]            base_data;
  mem_req_type            next_req, req;
  logic                   board_ce_n, module_ce_n, oe_n, cas_n, we_n;
  logic [1:0]             rom_word, ras_n, prev_ras;
  logic [DRAM_ADDR_W-1:0] dram_addr, prev_addr;
  logic                   prev_cas, board_s, module_s, oe_s, err_s, we_s;
  logic [2:0]             acks, ras0_f, ras1_f, cas_f;
  logic [1:0]             words [4], cols [4];
  int                     bad_count, n_compared;
  row_type                rows [13];

  memory_control_unit uut (.clock_i(clock_i), .reset_n_i(reset_n_i), .start_i(start),
    .req_i(req), .base_wr_i(base_wr), .base_sel_i(base_sel), .base_data_i(base_data),
    .rom_module_present_i(mod_in), .bank2_populated_i(b2_pop), .bank2_large_i(b2_large),
    .ack_o(ack), .error_o(error), .remap_o(remap), .rom_board_ce_n_o(board_ce_n),
    .rom_module_ce_n_o(module_ce_n), .rom_oe_n_o(oe_n), .rom_word_o(rom_word),
    .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n), .dram_addr_o(dram_addr));

  host_master_model host (.clock_i(clock_i), .reset_n_i(reset_n_i), .go_i(go),
    .next_req_i(next_req), .ack_i(ack), .error_i(error), .start_o(start), .req_o(req),
    .done_o(done));

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Refresh strobes are kept out: column falls count only under an open row
  always @(posedge clock_i) begin
    prev_ras <= ras_n;
    prev_cas  <= cas_n;
    prev_addr <= dram_addr;
    if (start) begin
      {acks, ras0_f, ras1_f, cas_f, board_s, module_s, oe_s, err_s, we_s} <= '0;
    end else begin
      // The column must already stand in the cycle before CAS falls
      if (prev_cas & ~cas_n & ~&ras_n) begin
        cols[cas_f[1:0]] <= prev_addr[1:0];
      end
      we_s     <= we_s | ~we_n;
      board_s  <= board_s | ~board_ce_n;
      module_s <= module_s | ~module_ce_n;
      oe_s     <= oe_s | ~oe_n;
      err_s    <= err_s | error;
      ras0_f   <= ras0_f + 3'(prev_ras[0] & ~ras_n[0] & cas_n);
      ras1_f   <= ras1_f + 3'(prev_ras[1] & ~ras_n[1] & cas_n);
      cas_f    <= cas_f + 3'(prev_cas & ~cas_n & ~&ras_n);
      if (ack) begin
        words[acks[1:0]] <= rom_word;
        acks             <= acks + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    n_compared++;
    if (exp !== seen) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic access(input row_type r);
    int         i;
    logic [2:0] beats;
    logic       ram;
    beats = r.burst ? 3'h4 : 3'h1;
    ram   = r.kind inside {K_B1, K_B2};
    @(posedge clock_i);
    next_req <= '{addr: r.addr, write: r.write, burst: r.burst};
    go       <= 1'b1;
    @(posedge clock_i);
    go <= 1'b0;
    @(negedge clock_i);
    for (i = 0; i < 400 && done !== 1'b1; i++) @(negedge clock_i);
    if (i == 400) begin
      check("access done", 8'h1, 8'h0);
      results();
    end
    check("ack count", (r.kind == K_ERR) ? 8'h0 : 8'(beats), 8'(acks));
    check("error", 8'(r.kind == K_ERR), 8'(err_s));
    check("board rom select", 8'(r.kind == K_ROM && !mod_in), 8'(board_s));
    check("module rom select", 8'(r.kind == K_ROM && mod_in), 8'(module_s));
    check("rom output enable", 8'(r.kind == K_ROM && !r.write), 8'(oe_s));
    check("bank one rows", 8'(r.kind == K_B1), 8'(ras0_f));
    check("bank two rows", 8'(r.kind == K_B2), 8'(ras1_f));
    check("column strobes", ram ? 8'(beats) : 8'h0, 8'(cas_f));
    check("dram write", 8'(ram && r.write), 8'(we_s));
    for (i = 0; i < beats; i++) begin
      if (r.kind == K_ROM) check("rom word", 8'(2'(r.addr[3:2] + 2'(i))), 8'(words[i]));
      if (ram) check("column", 8'(2'(r.addr[3:2] + 2'(i))), 8'(cols[i]));
    end
  endtask

  task automatic set_base(input logic sel, input logic [11:0] mb);
    @(posedge clock_i);
    base_wr   <= 1'b1;
    base_sel  <= sel;
    base_data <= mb;
    @(posedge clock_i);
    base_wr <= 1'b0;
  endtask

  // Straps pass two sync flops, so give them a few cycles before use
  task automatic straps(input logic m, input logic p, input logic l);
    @(posedge clock_i);
    mod_in   <= m;
    b2_pop   <= p;
    b2_large <= l;
    repeat (6) @(posedge clock_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {go, base_wr, base_sel, mod_in, b2_large, base_data} = '0;
    b2_pop     = 1'b1;
    next_req   = '0;
    reset_n_i  = 1'b0;
    bad_count  = 0;
    n_compared = 0;
    rows = '{'{32'h0000_0000, 1'b0, 1'b0, K_ROM}, '{32'h0000_0010, 1'b1, 1'b0, K_DROP},
             '{32'h0020_0000, 1'b0, 1'b0, K_ERR}, '{32'h4000_0000, 1'b0, 1'b0, K_ROM},
             '{32'h0000_0000, 1'b0, 1'b0, K_B1},  '{32'h0010_0008, 1'b0, 1'b1, K_B1},
             '{32'h0040_0004, 1'b1, 1'b0, K_B2},  '{32'h0070_000c, 1'b1, 1'b1, K_B2},
             '{32'h0080_0000, 1'b0, 1'b0, K_ERR}, '{32'h4000_0008, 1'b0, 1'b1, K_ROM},
             '{32'h400f_fffc, 1'b0, 1'b0, K_ROM}, '{32'h4010_0000, 1'b0, 1'b0, K_ERR},
             '{32'h003f_fffc, 1'b1, 1'b0, K_B1}};
    repeat (20) @(posedge clock_i);
    reset_n_i <= 1'b1;
    @(negedge clock_i);
    check("remap after reset", 8'h1, 8'(remap));
    check("rows idle", 8'h3, 8'(ras_n));
    for (int k = 0; k < 13; k++) access(rows[k]);
    check("remap left", 8'h0, 8'(remap));
    straps(1'b0, 1'b1, 1'b1);
    access(row_type'{32'h0130_0000, 1'b0, 1'b0, K_B2});
    set_base(1'b1, 12'h010);
    access(row_type'{32'h0040_0000, 1'b0, 1'b0, K_ERR});
    access(row_type'{32'h0100_0000, 1'b0, 1'b1, K_B2});
    set_base(1'b1, 12'h004);
    access(row_type'{32'h0040_0000, 1'b0, 1'b0, K_B2});
    straps(1'b0, 1'b0, 1'b0);
    access(row_type'{32'h0040_0000, 1'b0, 1'b0, K_ERR});
    straps(1'b1, 1'b1, 1'b0);
    access(row_type'{32'h4000_0004, 1'b0, 1'b1, K_ROM});
    @(posedge clock_i);
    reset_n_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    reset_n_i <= 1'b1;
    @(negedge clock_i);
    check("remap again", 8'h1, 8'(remap));
    // Idle long enough for a refresh to run while still in remap
    repeat (1600) @(posedge clock_i);
    @(negedge clock_i);
    check("remap kept", 8'h1, 8'(remap));
    access(row_type'{32'h0000_0004, 1'b0, 1'b0, K_ROM});
    access(row_type'{32'h0010_0000, 1'b0, 1'b0, K_ERR});
    results();
  end
endmodule
